// >>> logic/ics_params.svh
// Constants for the integrator chop sign control block.
// Assumes registers are reached by a plain address/data write-read port.
`ifndef ICS_PARAMS_SVH
`define ICS_PARAMS_SVH
`define ICS_ADDR_POL_A    8'h17
`define ICS_ADDR_POL_B    8'h1d
`define ICS_ADDR_MATH     8'h58
`define ICS_POL_RESET     16'h0000
`define ICS_MATH_RESET    16'h0000
`define ICS_POL_MSB       3
`define ICS_M12A_LSB      1
`define ICS_M34A_LSB      8
`define ICS_M12B_LSB      5
`define ICS_M34B_LSB      10
`endif

// >>> logic/ics_pkg.sv
// Types for the integrator chop sign control block.
// Assumes ics_params.svh is on the include path.
package ics_pkg;
    typedef struct packed {
        logic        start;   // First pulse of a new sample
        logic        valid;   // Digitised pulse result present
        logic        slot_b;  // 0 slot A, 1 slot B
        logic [19:0] data;    // Pulse result, two's complement
    } ics_pulse_t;

    typedef struct packed {
        logic        we;
        logic        re;
        logic [7:0]  addr;
        logic [15:0] wdata;
    } ics_reg_req_t;

    typedef enum logic {ICS_IDLE, ICS_ACCUM} ics_state_t;
endpackage

// >>> logic/ics_slot_acc.sv
// Per-slot pulse index and signed accumulation.
// Assumes pulses arrive one per valid strobe, start marks a new sample.
`timescale 1ns/1ps
`default_nettype none
module ics_slot_acc #(
    parameter int ACC_W = 27
) (
    input  wire logic               i_clk,
    input  wire logic               i_rstn,
    input  wire logic               i_ce,
    input  wire logic               i_valid,
    input  wire logic               i_start,
    input  wire logic [19:0]        i_data,
    input  wire logic [3:0]         i_pattern,
    input  wire logic [1:0]         i_m12,
    input  wire logic [1:0]         i_m34,
    output logic                    o_reversed,
    output logic [1:0]              o_index,
    output logic signed [ACC_W-1:0] o_acc
);
    import ics_pkg::*;

    logic [1:0]              next_index;
    logic [1:0]              cur_idx;
    logic                    next_reversed;
    logic signed [ACC_W-1:0] next_acc;
    logic signed [ACC_W-1:0] base;
    logic signed [ACC_W-1:0] term;
    logic                    sub;

    // Code bit 1 is the earlier pulse, bit 0 the later
    function automatic logic sign_of(input logic [1:0] idx,
                                     input logic [1:0] m12,
                                     input logic [1:0] m34);
        logic s;
        unique case (idx)
            2'h0: s = m12[1];
            2'h1: s = m12[0];
            2'h2: s = m34[1];
            2'h3: s = m34[0];
        endcase
        return s;
    endfunction

    always_comb begin
        cur_idx       = i_start ? 2'h0 : o_index;
        next_index    = o_index;
        next_reversed = o_reversed;
        next_acc      = o_acc;
        base          = i_start ? '0 : o_acc;
        term          = ACC_W'(signed'(i_data));
        sub           = sign_of(cur_idx, i_m12, i_m34);
        if (i_valid) begin
            next_reversed = i_pattern[cur_idx];
            next_index    = cur_idx + 2'h1;
            next_acc      = sub ? base - term : base + term;
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            o_index    <= 2'h0;
            o_reversed <= 1'b0;
            o_acc      <= '0;
        end else if (i_ce) begin
            o_index    <= next_index;
            o_reversed <= next_reversed;
            o_acc      <= next_acc;
        end
    end

    a_wrap_index: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && i_valid && !i_start && o_index == 2'h3 |=> o_index == 2'h0)
        else $error("Pulse index did not wrap");
    a_start_index: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && i_valid && i_start |=> o_index == 2'h1)
        else $error("Start did not restart index");
endmodule
`default_nettype wire

// >>> logic/ics_top.sv
// Integrator chop sign control: registers and both slot accumulators.
// Assumes a synchronous register port and pulse results from the ADC path.
`timescale 1ns/1ps
`default_nettype none
`include "ics_params.svh"
module ics_top #(
    parameter int ACC_W = 27
) (
    input  wire logic                i_clk,
    input  wire logic                i_rstn,
    input  wire logic                i_ce,
    input  wire ics_pkg::ics_reg_req_t i_req,
    input  wire ics_pkg::ics_pulse_t   i_pulse,
    output logic [15:0]              o_rdata,
    output logic                     o_rvalid,
    output logic                     o_reversed_a,
    output logic                     o_reversed_b,
    output logic signed [ACC_W-1:0]  o_acc_a,
    output logic signed [ACC_W-1:0]  o_acc_b
);
    import ics_pkg::*;

    // ****************************************
    // Registers
    // ****************************************
    logic [15:0] pol_a;
    logic [15:0] pol_b;
    logic [15:0] math;
    logic [15:0] next_pol_a;
    logic [15:0] next_pol_b;
    logic [15:0] next_math;
    logic [15:0] next_rdata;
    logic        next_rvalid;

    always_comb begin
        next_pol_a  = pol_a;
        next_pol_b  = pol_b;
        next_math   = math;
        next_rdata  = o_rdata;
        next_rvalid = i_req.re;
        if (i_req.we) begin
            unique case (i_req.addr)
                `ICS_ADDR_POL_A: next_pol_a = i_req.wdata;
                `ICS_ADDR_POL_B: next_pol_b = i_req.wdata;
                `ICS_ADDR_MATH:  next_math  = i_req.wdata;
                default: ;
            endcase
        end
        if (i_req.re) begin
            unique case (i_req.addr)
                `ICS_ADDR_POL_A: next_rdata = pol_a;
                `ICS_ADDR_POL_B: next_rdata = pol_b;
                `ICS_ADDR_MATH:  next_rdata = math;
                default:         next_rdata = 16'h0000;
            endcase
        end
    end

    always_ff @(posedge i_clk) begin
        if (!i_rstn) begin
            pol_a    <= `ICS_POL_RESET;
            pol_b    <= `ICS_POL_RESET;
            math     <= `ICS_MATH_RESET;
            o_rdata  <= 16'h0000;
            o_rvalid <= 1'b0;
        end else if (i_ce) begin
            pol_a    <= next_pol_a;
            pol_b    <= next_pol_b;
            math     <= next_math;
            o_rdata  <= next_rdata;
            o_rvalid <= next_rvalid;
        end
    end

    // ****************************************
    // Field decode
    // ****************************************
    logic [3:0] pattern_a;
    logic [3:0] pattern_b;
    logic [1:0] m12_a;
    logic [1:0] m34_a;
    logic [1:0] m12_b;
    logic [1:0] m34_b;

    assign pattern_a = pol_a[`ICS_POL_MSB:0];
    assign pattern_b = pol_b[`ICS_POL_MSB:0];
    // Two-bit combine code sitting at a given low bit
    function automatic logic [1:0] code_at(input logic [15:0] v,
                                           input int          lsb);
        return v[lsb +: 2];
    endfunction

    assign m12_a = code_at(math, `ICS_M12A_LSB);
    assign m34_a = code_at(math, `ICS_M34A_LSB);
    assign m12_b = code_at(math, `ICS_M12B_LSB);
    assign m34_b = code_at(math, `ICS_M34B_LSB);

    // ****************************************
    // Slot accumulators
    // ****************************************
    // Offsets and even pulse counts are software's job; not checked here
    logic valid_a;
    logic valid_b;
    assign valid_a = i_pulse.valid && !i_pulse.slot_b;
    assign valid_b = i_pulse.valid && i_pulse.slot_b;

    logic [1:0]              idx_a;
    logic [1:0]              idx_b;
    logic signed [ACC_W-1:0] pulse_term;
    // Sign-extended pulse, used only by the wrap checks below
    assign pulse_term = ACC_W'(signed'(i_pulse.data));

    ics_slot_acc #(.ACC_W(ACC_W)) u_acc_a (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_ce       (i_ce),
        .i_valid    (valid_a),
        .i_start    (i_pulse.start),
        .i_data     (i_pulse.data),
        .i_pattern  (pattern_a),
        .i_m12      (m12_a),
        .i_m34      (m34_a),
        .o_reversed (o_reversed_a),
        .o_index    (idx_a),
        .o_acc      (o_acc_a)
    );

    ics_slot_acc #(.ACC_W(ACC_W)) u_acc_b (
        .i_clk      (i_clk),
        .i_rstn     (i_rstn),
        .i_ce       (i_ce),
        .i_valid    (valid_b),
        .i_start    (i_pulse.start),
        .i_data     (i_pulse.data),
        .i_pattern  (pattern_b),
        .i_m12      (m12_b),
        .i_m34      (m34_b),
        .o_reversed (o_reversed_b),
        .o_index    (idx_b),
        .o_acc      (o_acc_b)
    );

    // ****************************************
    // Checks
    // ****************************************
    a_first_polarity: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_a && i_pulse.start
        |=> o_reversed_a == $past(pol_a[0]))
        else $error("Slot A first pulse polarity wrong");
    a_first_pol_b: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_b && i_pulse.start
        |=> o_reversed_b == $past(pol_b[0]))
        else $error("Slot B first pulse polarity wrong");
    a_start_add: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_a && i_pulse.start && math[2] == 1'b0
        |=> o_acc_a == ACC_W'(signed'($past(i_pulse.data))))
        else $error("Slot A first pulse not added");
    a_start_sub: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_b && i_pulse.start && math[6] == 1'b1
        |=> o_acc_b == -ACC_W'(signed'($past(i_pulse.data))))
        else $error("Slot B first pulse not subtracted");
    a_hold_acc: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !i_ce |=> $stable(o_acc_a) && $stable(o_acc_b))
        else $error("Accumulator moved with clock enable low");
    a_write_math: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && i_req.we && i_req.addr == `ICS_ADDR_MATH
        ##1 i_ce && i_req.re && !i_req.we && i_req.addr == `ICS_ADDR_MATH
        |=> o_rvalid && o_rdata == $past(i_req.wdata, 2))
        else $error("Math control readback wrong");

    // ****************************************
    // Per-pulse checks
    // ****************************************
    // Mid-group pulses take the bit at the running index
    a_pol_mid_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_a && !i_pulse.start
        |=> o_reversed_a == $past(pattern_a[idx_a]))
        else $error("Slot A polarity bit not followed");
    a_pol_mid_b: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_b && !i_pulse.start
        |=> o_reversed_b == $past(pattern_b[idx_b]))
        else $error("Slot B polarity bit not followed");
    // A wrapped group reuses the first code for pulses 5, 9 and on
    a_wrap_first_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_a && !i_pulse.start && idx_a == 2'h0
        |=> o_acc_a == $past(m12_a[1] ? o_acc_a - pulse_term
                                      : o_acc_a + pulse_term))
        else $error("Slot A wrapped first pulse sign wrong");
    a_wrap_last_a: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_a && !i_pulse.start && idx_a == 2'h3
        |=> o_acc_a == $past(m34_a[0] ? o_acc_a - pulse_term
                                      : o_acc_a + pulse_term))
        else $error("Slot A fourth pulse sign wrong");
    a_wrap_first_b: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_b && !i_pulse.start && idx_b == 2'h0
        |=> o_acc_b == $past(m12_b[1] ? o_acc_b - pulse_term
                                      : o_acc_b + pulse_term))
        else $error("Slot B wrapped first pulse sign wrong");
    a_wrap_last_b: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && valid_b && !i_pulse.start && idx_b == 2'h3
        |=> o_acc_b == $past(m34_b[0] ? o_acc_b - pulse_term
                                      : o_acc_b + pulse_term))
        else $error("Slot B fourth pulse sign wrong");

    // ****************************************
    // Register port, reset and hold checks, and covers
    // ****************************************
    a_unmapped_read: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && i_req.re
        && !(i_req.addr inside {`ICS_ADDR_POL_A, `ICS_ADDR_POL_B,
                                `ICS_ADDR_MATH})
        |=> o_rdata == 16'h0000)
        else $error("Unmapped read did not return zero");
    a_rvalid_single: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        i_ce && !i_req.re |=> !o_rvalid)
        else $error("Read valid without a read");
    // Reset wins over a low clock enable
    a_reset_clear: assert property (
        @(posedge i_clk)
        !i_rstn |=> o_acc_a == '0 && o_acc_b == '0 && o_rdata == 16'h0000
                    && !o_rvalid && !o_reversed_a && !o_reversed_b)
        else $error("Outputs not cleared by reset");
    a_hold_flags: assert property (
        @(posedge i_clk) disable iff (!i_rstn)
        !i_ce |=> $stable(o_reversed_a) && $stable(o_reversed_b)
                  && $stable(o_rdata))
        else $error("Flags moved with clock enable low");

    c_sample_a: cover property (@(posedge i_clk) disable iff (!i_rstn)
        valid_a && i_pulse.start ##2 valid_a ##2 valid_a ##2 valid_a);
    c_sample_b: cover property (@(posedge i_clk) disable iff (!i_rstn)
        valid_b && i_pulse.start ##2 valid_b);
    c_reversed: cover property (@(posedge i_clk) disable iff (!i_rstn)
        o_reversed_a && o_reversed_b);
    c_group_wrap: cover property (@(posedge i_clk) disable iff (!i_rstn)
        valid_a && !i_pulse.start && idx_a == 2'h0);
    c_write_read: cover property (@(posedge i_clk) disable iff (!i_rstn)
        i_req.we ##1 i_req.re && !i_req.we);
endmodule
`default_nettype wire

// >>> verification/tb.sv
// Self-checking bench for ics_top: register port and both slot sums.
// Assumes ics_params.svh on the include path; drives ports directly.
`timescale 1ns/1ps
`default_nettype none
`include "ics_params.svh"
module tb;
    import ics_pkg::*;
    localparam int AW = 27;
    logic                 i_clk;
    logic                 i_rstn;
    logic                 i_ce;
    ics_reg_req_t         i_req;
    ics_pulse_t           i_pulse;
    logic [15:0]          o_rdata;
    logic                 o_rvalid;
    logic                 o_reversed_a;
    logic                 o_reversed_b;
    logic signed [AW-1:0] o_acc_a;
    logic signed [AW-1:0] o_acc_b;
    int                   bad_count;
    int                   checks;
    typedef struct packed {
        logic [3:0] pat;
        logic [1:0] m12;
        logic [1:0] m34;
    } ics_row_t;
    // Across the four rows m12 and m34 each take every code once
    ics_row_t rows [4] = '{'{4'ha, 2'b01, 2'b10}, '{4'h5, 2'b10, 2'b01},
                           '{4'h0, 2'b00, 2'b11}, '{4'hf, 2'b11, 2'b00}};
    logic [15:0]          d;
    logic [15:0]          mv;
    logic signed [19:0]   dv;
    logic signed [AW-1:0] ex;
    logic                 ng;
    logic [1:0]           ix;

    ics_top #(.ACC_W(AW)) u_ics_top (.i_clk(i_clk), .i_rstn(i_rstn),
        .i_ce(i_ce), .i_req(i_req), .i_pulse(i_pulse), .o_rdata(o_rdata),
        .o_rvalid(o_rvalid), .o_reversed_a(o_reversed_a),
        .o_reversed_b(o_reversed_b), .o_acc_a(o_acc_a), .o_acc_b(o_acc_b));

    // ************************************************
    // Tasks
    // ************************************************
    task automatic check(string what, logic [AW-1:0] seen, logic [AW-1:0] e);
        checks++;
        if (seen !== e) begin
            bad_count++;
            $display("mismatch %s expected %h seen %h", what, e, seen);
        end
    endtask
    task automatic close_out();
        $display("checks %0d mismatches %0d", checks, bad_count);
        if (bad_count == 0 && checks > 0) $display("bench passed");
        else $display("bench failed");
        $finish;
    endtask
    // Every driving task opens on a fresh edge so no signal is driven twice
    task automatic reg_wr(logic [7:0] a, logic [15:0] v);
        @(posedge i_clk);
        i_req <= '{we: 1'b1, re: 1'b0, addr: a, wdata: v};
        @(posedge i_clk);
        i_req.we <= 1'b0;
    endtask
    task automatic reg_rd(logic [7:0] a, output logic [15:0] v);
        @(posedge i_clk);
        i_req <= '{we: 1'b0, re: 1'b1, addr: a, wdata: 16'h0000};
        @(posedge i_clk);
        i_req.re <= 1'b0;
        #1;
        check("rvalid", AW'(o_rvalid), AW'(1'b1));
        v = o_rdata;
    endtask
    task automatic pulse(logic sl, logic st, logic [19:0] v);
        @(posedge i_clk);
        i_pulse <= '{start: st, valid: 1'b1, slot_b: sl, data: v};
        @(posedge i_clk);
        i_pulse.valid <= 1'b0;
        #1;
    endtask

    initial begin
        i_clk = 1'b0;
        forever #2.5 i_clk = ~i_clk;
    end
    initial begin
        #200000;
        bad_count++;
        close_out();
    end

    // ************************************************
    // Main sequence
    // ************************************************
    initial begin
        i_rstn = 1'b0;
        i_ce = 1'b1;
        i_req = '0;
        i_pulse = '0;
        bad_count = 0;
        checks = 0;
        repeat (20) @(posedge i_clk);
        i_rstn <= 1'b1;
        // Offsets live outside this block, nothing to zero
        for (int s = 0; s < 2; s++) begin
            for (int r = 0; r < 4; r++) begin
                // Other slot gets inverted settings to expose swaps
                mv = 16'h9000;
                mv[2:1] = s ? ~rows[r].m12 : rows[r].m12;
                mv[9:8] = s ? ~rows[r].m34 : rows[r].m34;
                mv[6:5] = s ? rows[r].m12 : ~rows[r].m12;
                mv[11:10] = s ? rows[r].m34 : ~rows[r].m34;
                reg_wr(`ICS_ADDR_MATH, mv);
                reg_wr(`ICS_ADDR_POL_A,
                       {12'h0, s ? ~rows[r].pat : rows[r].pat});
                reg_wr(`ICS_ADDR_POL_B,
                       {12'h0, s ? rows[r].pat : ~rows[r].pat});
                reg_rd(`ICS_ADDR_MATH, d);
                check("math", AW'(d), AW'(mv));
                // Ten pulses: even count, wraps the group twice
                for (int k = 0; k < 10; k++) begin
                    ix = 2'(k % 4);
                    ng = ix[1] ? rows[r].m34[~ix[0]] : rows[r].m12[~ix[0]];
                    dv = (k % 3 == 1) ? -20'(k * 1111 + 7) : 20'(k * 1111 + 7);
                    ex = (k == 0) ? AW'(0) : ex;
                    ex = ng ? ex - dv : ex + dv;
                    pulse(1'(s), k == 0, dv);
                    check("rev", AW'(s ? o_reversed_b : o_reversed_a),
                          AW'(rows[r].pat[ix]));
                    check("acc", s ? o_acc_b : o_acc_a,
                        ex);
                end
            end
        end
        $display("test rows done");
        // Restart in mid-group, other slot untouched
        // Last row left slot A adding pulses 1 and 2, subtracting 3 and 4
        reg_wr(`ICS_ADDR_POL_A, 16'h000e);
        pulse(1'b0, 1'b1, 20'h00100);
        pulse(1'b0, 1'b0, 20'h00100);
        pulse(1'b0, 1'b0, 20'h00100);
        ex = o_acc_b;
        pulse(1'b0, 1'b1, 20'h00040);
        check("restart acc", o_acc_a, AW'(64));
        check("restart rev", AW'(o_reversed_a), AW'(1'b0));
        check("slot b kept", o_acc_b, ex);
        $display("test restart done");
        // Clock enable low freezes the sum
        @(posedge i_clk);
        i_ce <= 1'b0;
        pulse(1'b0, 1'b0, 20'h00333);
        check("frozen acc", o_acc_a, AW'(64));
        @(posedge i_clk);
        i_ce <= 1'b1;
        $display("test freeze done");
        // Unmapped place: write ignored, read gives zero
        reg_wr(8'h20, 16'hbeef);
        reg_rd(8'h20, d);
        check("unmapped", AW'(d), AW'(16'h0000));
        reg_rd(`ICS_ADDR_POL_A, d);
        check("pol a kept", AW'(d), AW'(16'h000e));
        $display("test unmapped done");
        // Write and read together give the old word, then the new one
        @(posedge i_clk);
        i_req <= '{we: 1'b1, re: 1'b1, addr: `ICS_ADDR_MATH, wdata: 16'h0a5a};
        @(posedge i_clk);
        i_req <= '{we: 1'b0, re: 1'b1, addr: `ICS_ADDR_MATH, wdata: 16'h0000};
        #1;
        check("old math", AW'(o_rdata), AW'(mv));
        @(posedge i_clk);
        i_req.re <= 1'b0;
        #1;
        check("b2b rvalid", AW'(o_rvalid), AW'(1'b1));
        check("new math", AW'(o_rdata), AW'(16'h0a5a));
        $display("test back to back done");
        // Second reset in mid-run clears sums and registers
        @(posedge i_clk);
        i_rstn <= 1'b0;
        @(posedge i_clk);
        i_rstn <= 1'b1;
        #1;
        check("rst acc a", o_acc_a, AW'(0));
        check("rst acc b", o_acc_b, AW'(0));
        check("rst rev a", AW'(o_reversed_a), AW'(1'b0));
        check("rst rev b", AW'(o_reversed_b), AW'(1'b0));
        reg_rd(`ICS_ADDR_POL_A, d);
        check("rst pol a", AW'(d), AW'(`ICS_POL_RESET));
        reg_rd(`ICS_ADDR_POL_B, d);
        check("rst pol b", AW'(d), AW'(`ICS_POL_RESET));
        reg_rd(`ICS_ADDR_MATH, d);
        check("rst math", AW'(d), AW'(`ICS_MATH_RESET));
        $display("test reset done");
        close_out();
    end
endmodule
`default_nettype wire
